//--- rtl/aamc_map.svh
`ifndef AAMC_MAP_SVH
`define AAMC_MAP_SVH

`define AAMC_ADDR_TEMP_RESULT 8'hd7
`define AAMC_ADDR_CONV_START  8'hd8
`define AAMC_ADDR_BATT_RESULT 8'hdf
`define AAMC_ADDR_EXT_RESULT  8'hef
`define AAMC_ADDR_DELTA_CFG   8'hf3
`define AAMC_ADDR_STROBE_PER  8'hf9
`define AAMC_ADDR_BATT_THR    8'hfa

`define AAMC_RST_BYTE         8'h00

`define AAMC_GO_BATT_BIT      0
`define AAMC_GO_TEMP_BIT      1
`define AAMC_GO_EXT_BIT       2
`define AAMC_PLL_ACK_BIT      7
`define AAMC_EXT_DELTA_LSB    0
`define AAMC_TEMP_DELTA_LSB   3
`define AAMC_TEMP_PER_LSB     0
`define AAMC_CFG_USED_BITS    6

`define AAMC_DELTA_OFF        3'h0
`define AAMC_DELTA_EVERY      3'h7

`define AAMC_PER_CODE_8MIN    2'h1
`define AAMC_PER_CODE_2MIN    2'h2
`define AAMC_PER_CODE_1MIN    2'h3
`define AAMC_PER_8MIN         4'h8
`define AAMC_PER_2MIN         4'h2
`define AAMC_PER_1MIN         4'h1

`define AAMC_CLK_HZ           50000000
`define AAMC_MINUTE_S         60
`define AAMC_MINUTE_CYCLES    (64'(`AAMC_MINUTE_S) * 64'(`AAMC_CLK_HZ))
`endif

//--- rtl/aamc_pkg.sv
package aamc_pkg;
`include "aamc_map.svh"

    typedef enum logic [1:0] {
        FULL_POWER_MODE,
        BATTERY_ACTIVE_MODE,
        SLEEP_MODE
    } aamc_mode_t;

    // answer from one converter
    typedef struct packed {
        logic       ack;
        logic       done;
        logic [7:0] data;
    } aamc_conv_in_t;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_WAIT_ACK,
        CH_CONVERT
    } aamc_ch_state_t;

    function automatic logic [3:0] aamc_period_minutes(input logic [1:0] code);
        logic [3:0] m;
        m = 4'h0;
        case (code)
            `AAMC_PER_CODE_8MIN: m = `AAMC_PER_8MIN;
            `AAMC_PER_CODE_2MIN: m = `AAMC_PER_2MIN;
            `AAMC_PER_CODE_1MIN: m = `AAMC_PER_1MIN;
            default:             m = 4'h0;
        endcase
        return m;
    endfunction
endpackage

//--- rtl/aamc_interval_timer.sv
`timescale 1ns/1ps
`include "aamc_map.svh"
module aamc_interval_timer
    import aamc_pkg::*;
#(
    parameter logic [31:0] MINUTE_CYCLES = 32'(`AAMC_MINUTE_CYCLES)
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [1:0] i_period_sel,
    input  wire logic       i_run,
    output logic            o_strobe
);
    logic [31:0] pre;
    logic [3:0]  mins;
    logic [31:0] next_pre;
    logic [3:0]  next_mins;
    logic        next_strobe;
    logic [3:0]  target;

    always_comb begin
        target      = aamc_period_minutes(i_period_sel);
        next_pre    = pre;
        next_mins   = mins;
        next_strobe = 1'b0;
        if (!i_run || target == 4'h0) begin
            next_pre  = 32'h0;
            next_mins = 4'h0;
        end else if (pre >= MINUTE_CYCLES - 32'h1) begin
            next_pre = 32'h0;
            if (mins + 4'h1 >= target) begin
                next_mins   = 4'h0;
                next_strobe = 1'b1;
            end else begin
                next_mins = mins + 4'h1;
            end
        end else begin
            next_pre = pre + 32'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pre      <= 32'h0;
            mins     <= 4'h0;
            o_strobe <= 1'b0;
        end else begin
            pre      <= next_pre;
            mins     <= next_mins;
            o_strobe <= next_strobe;
        end
    end

    AST_NO_STROBE_WHEN_OFF: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (aamc_period_minutes(i_period_sel) == 4'h0) |=> !o_strobe)
        else $error("interval strobe while interval is off");
endmodule

//--- rtl/aamc_channel.sv
`timescale 1ns/1ps
`include "aamc_map.svh"
module aamc_channel
    import aamc_pkg::*;
#(
    parameter bit IS_DELTA = 1'b1
) (
    input  wire logic          i_clk,
    input  wire logic          i_sys_rst,
    input  wire logic          i_sw_go,
    input  wire logic          i_allow_sw,
    input  wire logic          i_bg_go,
    input  wire logic          i_allow_bg,
    input  wire logic [2:0]    i_delta_sel,
    input  wire logic [7:0]    i_threshold,
    input  wire aamc_conv_in_t i_conv,
    output logic               o_req,
    output logic               o_accept,
    output logic               o_irq,
    output logic [7:0]         o_result
);
    aamc_ch_state_t st;
    aamc_ch_state_t next_st;
    logic           single;
    logic           next_single;
    logic           bg_pend;
    logic           next_bg_pend;
    logic [7:0]     ref_val;
    logic [7:0]     next_ref_val;
    logic [7:0]     next_result;
    logic           next_irq;

    // background or threshold condition on a finished conversion
    function automatic logic hit_cond(input logic [7:0] v, input logic [7:0] r,
                                      input logic [2:0] sel, input logic [7:0] thr);
        logic [7:0] diff;
        logic       hit;
        diff = (v > r) ? (v - r) : (r - v);
        hit  = 1'b0;
        if (!IS_DELTA) begin
            hit = (v < thr);
        end else if (sel == `AAMC_DELTA_OFF) begin
            hit = 1'b0;
        end else if (sel == `AAMC_DELTA_EVERY) begin
            hit = 1'b1;
        end else begin
            hit = (diff > {5'h0, sel});
        end
        return hit;
    endfunction

    always_comb begin
        next_st      = st;
        next_single  = single;
        next_bg_pend = bg_pend;
        next_ref_val = ref_val;
        next_result  = o_result;
        next_irq     = 1'b0;
        o_accept     = 1'b0;
        o_req        = (st == CH_WAIT_ACK);
        if (!i_allow_bg) begin
            next_bg_pend = 1'b0;
        end
        case (st)
            CH_IDLE: begin
                if (i_sw_go && i_allow_sw) begin
                    next_single = 1'b1;
                    next_st     = CH_WAIT_ACK;
                end else if (bg_pend && i_allow_bg) begin
                    next_single  = 1'b0;
                    next_bg_pend = 1'b0;
                    next_st      = CH_WAIT_ACK;
                end
            end
            CH_WAIT_ACK: begin
                if (i_conv.ack) begin
                    o_accept = single;
                    next_st  = CH_CONVERT;
                end
            end
            CH_CONVERT: begin
                if (i_conv.done) begin
                    next_st = CH_IDLE;
                    if (single || hit_cond(i_conv.data, ref_val, i_delta_sel, i_threshold)) begin
                        next_irq     = 1'b1;
                        next_result  = i_conv.data;
                        next_ref_val = i_conv.data;
                    end
                end
            end
            default: next_st = CH_IDLE;
        endcase
        // a strobe during a conversion waits for the next idle slot
        if (i_bg_go && i_allow_bg) begin
            next_bg_pend = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st       <= CH_IDLE;
            single   <= 1'b0;
            bg_pend  <= 1'b0;
            ref_val  <= `AAMC_RST_BYTE;
            o_result <= `AAMC_RST_BYTE;
            o_irq    <= 1'b0;
        end else begin
            st       <= next_st;
            single   <= next_single;
            bg_pend  <= next_bg_pend;
            ref_val  <= next_ref_val;
            o_result <= next_result;
            o_irq    <= next_irq;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    AST_RESULT_ONLY_ON_IRQ: assert property ($changed(o_result) |-> o_irq)
        else $error("result changed without interrupt");
    AST_BATT_LOW: assert property (!IS_DELTA && st == CH_CONVERT && i_conv.done
        && i_conv.data < i_threshold |=> o_irq && o_result == $past(i_conv.data))
        else $error("low battery result did not interrupt");
    AST_BATT_OK_BG: assert property (!IS_DELTA && st == CH_CONVERT && i_conv.done
        && !single && i_conv.data >= i_threshold |=> !o_irq && $stable(o_result))
        else $error("battery at threshold interrupted");
    AST_SINGLE_DONE: assert property (st == CH_CONVERT && i_conv.done && single
        |=> o_irq ##0 o_result == $past(i_conv.data))
        else $error("single conversion did not interrupt");
    AST_DELTA_OFF: assert property (IS_DELTA && st == CH_CONVERT && i_conv.done
        && !single && i_delta_sel == `AAMC_DELTA_OFF |=> !o_irq)
        else $error("delta off yet background interrupt");
    AST_DELTA_EVERY: assert property (IS_DELTA && st == CH_CONVERT && i_conv.done
        && i_delta_sel == `AAMC_DELTA_EVERY |=> o_irq)
        else $error("every-conversion code missed interrupt");
    AST_REF_TRACK: assert property (o_irq |-> ref_val == o_result)
        else $error("reference not updated on interrupt");
    AST_NO_SW_WHEN_BARRED: assert property (st == CH_IDLE && !i_allow_sw && !bg_pend
        |=> st == CH_IDLE)
        else $error("single conversion launched while barred");
endmodule

//--- rtl/aamc_top.sv
`timescale 1ns/1ps
`include "aamc_map.svh"
module aamc_top
    import aamc_pkg::*;
#(
    parameter logic [31:0] MINUTE_CYCLES = 32'(`AAMC_MINUTE_CYCLES)
) (
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    input  wire logic [7:0]          i_sfr_addr,
    input  wire logic                i_sfr_wr,
    input  wire logic [7:0]          i_sfr_wdata,
    output logic [7:0]               o_sfr_rdata,
    input  wire aamc_mode_t          i_power_mode,
    input  wire logic                i_pll_fault_set,
    output logic                     o_pll_lock_fault,
    input  wire aamc_conv_in_t [2:0] i_conv,
    output logic [2:0]               o_conv_req,
    output logic [2:0]               o_conv_irq
);
    logic [2:0]                      start_bits;
    logic [2:0]                      next_start_bits;
    logic                            next_pll_fault;
    logic [`AAMC_CFG_USED_BITS-1:0]  delta_cfg;
    logic [`AAMC_CFG_USED_BITS-1:0]  next_delta_cfg;
    logic [`AAMC_CFG_USED_BITS-1:0]  strobe_per;
    logic [`AAMC_CFG_USED_BITS-1:0]  next_strobe_per;
    logic [7:0]                      batt_thr;
    logic [7:0]                      next_batt_thr;
    logic [7:0]                      next_rdata;
    logic [2:0]                      accept;
    logic [2:0]                      bg_go;
    logic [2:0][2:0]                 delta_sel;
    logic [2:0][7:0]                 result;
    logic                            allow_sw;
    logic                            allow_bg;
    logic                            temp_strobe;
    logic                            wr_start;

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target, input logic w);
        return w && (a == target);
    endfunction

    assign allow_sw = (i_power_mode != SLEEP_MODE);
    assign allow_bg = (i_power_mode != BATTERY_ACTIVE_MODE);
    assign wr_start = wr_hit(i_sfr_addr, `AAMC_ADDR_CONV_START, i_sfr_wr);

    // configuration and start registers
    always_comb begin
        next_delta_cfg  = delta_cfg;
        next_strobe_per = strobe_per;
        next_batt_thr   = batt_thr;
        next_pll_fault  = o_pll_lock_fault;
        next_start_bits = start_bits & ~accept;
        if (wr_start) begin
            next_start_bits = next_start_bits | i_sfr_wdata[`AAMC_GO_EXT_BIT:`AAMC_GO_BATT_BIT];
            if (i_sfr_wdata[`AAMC_PLL_ACK_BIT]) begin
                next_pll_fault = 1'b0;
            end
        end
        if (i_pll_fault_set) begin
            next_pll_fault = 1'b1;
        end
        if (wr_hit(i_sfr_addr, `AAMC_ADDR_DELTA_CFG, i_sfr_wr)) begin
            next_delta_cfg = i_sfr_wdata[`AAMC_CFG_USED_BITS-1:0];
        end
        if (wr_hit(i_sfr_addr, `AAMC_ADDR_STROBE_PER, i_sfr_wr)) begin
            next_strobe_per = i_sfr_wdata[`AAMC_CFG_USED_BITS-1:0];
        end
        if (wr_hit(i_sfr_addr, `AAMC_ADDR_BATT_THR, i_sfr_wr)) begin
            next_batt_thr = i_sfr_wdata;
        end
    end

    // read data, one cycle after the address
    always_comb begin
        case (i_sfr_addr)
            `AAMC_ADDR_TEMP_RESULT: next_rdata = result[`AAMC_GO_TEMP_BIT];
            `AAMC_ADDR_BATT_RESULT: next_rdata = result[`AAMC_GO_BATT_BIT];
            `AAMC_ADDR_EXT_RESULT:  next_rdata = result[`AAMC_GO_EXT_BIT];
            `AAMC_ADDR_CONV_START:  next_rdata = {5'h0, start_bits};
            `AAMC_ADDR_DELTA_CFG:   next_rdata = {2'h0, delta_cfg};
            `AAMC_ADDR_STROBE_PER:  next_rdata = {2'h0, strobe_per};
            `AAMC_ADDR_BATT_THR:    next_rdata = batt_thr;
            default:                next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            start_bits       <= 3'h0;
            o_pll_lock_fault <= 1'b0;
            delta_cfg        <= '0;
            strobe_per       <= '0;
            batt_thr         <= `AAMC_RST_BYTE;
            o_sfr_rdata      <= 8'h00;
        end else begin
            start_bits       <= next_start_bits;
            o_pll_lock_fault <= next_pll_fault;
            delta_cfg        <= next_delta_cfg;
            strobe_per       <= next_strobe_per;
            batt_thr         <= next_batt_thr;
            o_sfr_rdata      <= next_rdata;
        end
    end

    aamc_interval_timer #(
        .MINUTE_CYCLES (MINUTE_CYCLES)
    ) u_temp_timer (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_period_sel (strobe_per[`AAMC_TEMP_PER_LSB+1:`AAMC_TEMP_PER_LSB]),
        .i_run        (allow_bg),
        .o_strobe     (temp_strobe)
    );

    assign bg_go = {1'b0, temp_strobe, 1'b0};
    assign delta_sel[`AAMC_GO_BATT_BIT] = `AAMC_DELTA_OFF;
    assign delta_sel[`AAMC_GO_TEMP_BIT] = delta_cfg[`AAMC_TEMP_DELTA_LSB+2:`AAMC_TEMP_DELTA_LSB];
    assign delta_sel[`AAMC_GO_EXT_BIT]  = delta_cfg[`AAMC_EXT_DELTA_LSB+2:`AAMC_EXT_DELTA_LSB];

    // channel index equals its start bit position
    for (genvar g = 0; g < 3; g++) begin : g_ch
        aamc_channel #(
            .IS_DELTA (g != `AAMC_GO_BATT_BIT)
        ) u_ch (
            .i_clk       (i_clk),
            .i_sys_rst   (i_sys_rst),
            .i_sw_go     (start_bits[g]),
            .i_allow_sw  (allow_sw),
            .i_bg_go     (bg_go[g]),
            .i_allow_bg  (allow_bg),
            .i_delta_sel (delta_sel[g]),
            .i_threshold (batt_thr),
            .i_conv      (i_conv[g]),
            .o_req       (o_conv_req[g]),
            .o_accept    (accept[g]),
            .o_irq       (o_conv_irq[g]),
            .o_result    (result[g])
        );
    end

    AST_GO_SELF_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        accept[`AAMC_GO_TEMP_BIT] && !wr_start |=> !start_bits[`AAMC_GO_TEMP_BIT])
        else $error("temperature start bit not cleared on accept");
    AST_GO_HELD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        start_bits[`AAMC_GO_BATT_BIT] && !accept[`AAMC_GO_BATT_BIT]
        |=> start_bits[`AAMC_GO_BATT_BIT])
        else $error("battery start bit dropped before accept");
    AST_EXT_GO_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wr_start && i_sfr_wdata[`AAMC_GO_EXT_BIT] |=> start_bits[`AAMC_GO_EXT_BIT])
        else $error("ext volt start write lost");
    AST_PLL_ACK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        wr_start && i_sfr_wdata[`AAMC_PLL_ACK_BIT] && !i_pll_fault_set |=> !o_pll_lock_fault)
        else $error("pll fault not acknowledged");
    AST_NO_BG_BATT_MODE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_power_mode == BATTERY_ACTIVE_MODE ##1 i_power_mode == BATTERY_ACTIVE_MODE
        |-> !temp_strobe)
        else $error("background strobe in battery active mode");
    AST_TEMP_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_sfr_addr == `AAMC_ADDR_TEMP_RESULT |=> o_sfr_rdata == $past(result[`AAMC_GO_TEMP_BIT]))
        else $error("temperature result readback wrong");
endmodule

//--- tb/aamc_conv_model.sv
`timescale 1ns/1ps
module aamc_conv_model
    import aamc_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic [2:0]      i_req,
    input  wire logic [2:0][7:0] i_value,
    input  wire logic            i_slow,
    output aamc_conv_in_t [2:0]  o_conv
);
    int         wait_cnt [3];
    int         conv_cnt [3];
    logic [7:0] filler;

    initial begin
        o_conv   = '0;
        filler   = 8'h5a;
        wait_cnt = '{0, 0, 0};
        conv_cnt = '{0, 0, 0};
    end

    // accept after a short or long stall, answer a few cycles later
    always @(posedge i_clk) begin
        filler <= ~filler;
        for (int c = 0; c < 3; c++) begin
            o_conv[c].ack  <= 1'b0;
            o_conv[c].done <= 1'b0;
            // data between answers is filler, which toggles between 5a and a5 every cycle
            o_conv[c].data <= filler;
            if (i_req[c] && !o_conv[c].ack && conv_cnt[c] == 0) begin
                wait_cnt[c] <= wait_cnt[c] + 1;
                if (wait_cnt[c] >= (i_slow ? 5 : 1)) begin
                    o_conv[c].ack <= 1'b1;
                    wait_cnt[c]   <= 0;
                    conv_cnt[c]   <= i_slow ? 6 : 3;
                end
            end
            if (conv_cnt[c] == 1) begin
                o_conv[c].done <= 1'b1;
                o_conv[c].data <= i_value[c];
            end
            if (conv_cnt[c] > 0) conv_cnt[c] <= conv_cnt[c] - 1;
        end
    end
endmodule

//--- tb/tb_aux_adc_measure_control.sv
`timescale 1ns/1ps
module tb_aux_adc_measure_control;
    import aamc_pkg::*;
    localparam int MIN_CYC = 20;
    logic                i_clk;
    logic                i_sys_rst;
    logic [7:0]          sfr_addr;
    logic                sfr_wr;
    logic [7:0]          sfr_wdata;
    logic [7:0]          sfr_rdata;
    aamc_mode_t          power_mode;
    logic                pll_set;
    logic                pll_fault;
    aamc_conv_in_t [2:0] conv;
    logic [2:0]          conv_req;
    logic [2:0]          conv_irq;
    logic [2:0][7:0]     conv_value;
    logic                slow;
    int                  miscompares;
    int                  n_compared;
    int                  cycles;

    aamc_top #(.MINUTE_CYCLES(32'(MIN_CYC))) dut (
        .i_clk            (i_clk),
        .i_sys_rst        (i_sys_rst),
        .i_sfr_addr       (sfr_addr),
        .i_sfr_wr         (sfr_wr),
        .i_sfr_wdata      (sfr_wdata),
        .o_sfr_rdata      (sfr_rdata),
        .i_power_mode     (power_mode),
        .i_pll_fault_set  (pll_set),
        .o_pll_lock_fault (pll_fault),
        .i_conv           (conv),
        .o_conv_req       (conv_req),
        .o_conv_irq       (conv_irq)
    );

    aamc_conv_model u_conv (
        .i_clk   (i_clk),
        .i_req   (conv_req),
        .i_value (conv_value),
        .i_slow  (slow),
        .o_conv  (conv)
    );

    initial i_clk = 1'b0;
    always #10 i_clk = ~i_clk;

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED at %0t: run timed out", $time);
            report_and_stop();
        end
    end

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // called at a falling edge, returns one idle cycle later
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge i_clk);
        sfr_wr = 1'b0;
        @(negedge i_clk);
    endtask

    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        @(negedge i_clk);
        check8(sfr_rdata, exp, "register read");
    endtask

    task automatic wait_bit(input logic want_req, input int ch, input int limit,
                            output logic seen);
        seen = 1'b0;
        for (int k = 0; k < limit && !seen; k++) begin
            @(negedge i_clk);
            seen = ((want_req ? conv_req[ch] : conv_irq[ch]) === 1'b1);
        end
    endtask

    task automatic t_reset_regs();
        logic [7:0] addrs [7] = '{8'hd7, 8'hd8, 8'hdf, 8'hef, 8'hf3, 8'hf9, 8'hfa};
        foreach (addrs[k]) check_reg(addrs[k], 8'h00);
        check_reg(8'h00, 8'h00);
        sfr_write(8'hd7, 8'ha5);
        check_reg(8'hd7, 8'h00);
        sfr_write(8'hf3, 8'hff);
        check_reg(8'hf3, 8'h3f);
        sfr_write(8'hfa, 8'h81);
        check_reg(8'hfa, 8'h81);
        check8({7'h0, pll_fault}, 8'h00, "pll flag at reset");
        $display("test reset_regs done");
    endtask

    task automatic t_single();
        logic [7:0] res_addr [3] = '{8'hdf, 8'hd7, 8'hef};
        logic       seen;
        slow       = 1'b1;
        power_mode = BATTERY_ACTIVE_MODE;
        for (int ch = 0; ch < 3; ch++) begin
            conv_value[ch] = 8'h30 + 8'(ch);
            sfr_write(8'hd8, 8'h01 << ch);
            check_reg(8'hd8, 8'h01 << ch);
            wait_bit(1'b0, ch, 100, seen);
            check8({7'h0, seen}, 8'h01, "single irq");
            conv_value[ch] = 8'hc0;
            repeat (10) @(negedge i_clk);
            check_reg(8'hd8, 8'h00);
            check_reg(res_addr[ch], 8'h30 + 8'(ch));
        end
        power_mode = FULL_POWER_MODE;
        slow       = 1'b0;
        $display("test single done");
    endtask

    task automatic t_sleep_single();
        logic seen;
        power_mode = SLEEP_MODE;
        sfr_write(8'hd8, 8'h02);
        wait_bit(1'b1, 1, 60, seen);
        check8({7'h0, seen}, 8'h00, "single in sleep");
        power_mode = FULL_POWER_MODE;
        wait_bit(1'b0, 1, 60, seen);
        check8({7'h0, seen}, 8'h01, "single after sleep");
        $display("test sleep_single done");
    endtask

    task automatic t_interval();
        int   mins [3] = '{8, 2, 1};
        int   n;
        logic seen;
        conv_value[1] = 8'h40;
        sfr_write(8'hf3, 8'h38);
        for (int code = 1; code < 4; code++) begin
            sfr_write(8'hf9, 8'(code));
            n = 0;
            while (conv_req[1] !== 1'b1 && n < 400) begin
                @(negedge i_clk);
                n++;
            end
            check8(8'(n >= mins[code-1] * MIN_CYC - 3 && n <= mins[code-1] * MIN_CYC + 3),
                   8'h01, "interval length");
            wait_bit(1'b0, 1, 30, seen);
            check8({7'h0, seen}, 8'h01, "every-conversion irq");
            sfr_write(8'hf9, 8'h00);
        end
        wait_bit(1'b1, 1, 200, seen);
        check8({7'h0, seen}, 8'h00, "background off");
        $display("test interval done");
    endtask

    task automatic t_delta();
        logic [7:0] vals [4] = '{8'd101, 8'd103, 8'd105, 8'd100};
        logic       hits [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic [7:0] exp_res;
        logic       seen;
        conv_value[1] = 8'd100;
        sfr_write(8'hd8, 8'h02); // single conversion first
        wait_bit(1'b0, 1, 60, seen);
        check8({7'h0, seen}, 8'h01, "seed irq");
        sfr_write(8'hf3, 8'h10); // then a delta of two
        sfr_write(8'hf9, 8'h03); // then a one-minute interval
        exp_res = 8'd100;
        foreach (vals[k]) begin
            conv_value[1] = vals[k];
            wait_bit(1'b1, 1, 60, seen);
            wait_bit(1'b0, 1, 15, seen);
            check8({7'h0, seen}, {7'h0, hits[k]}, "delta irq");
            if (hits[k]) exp_res = vals[k];
            check_reg(8'hd7, exp_res);
        end
        power_mode = BATTERY_ACTIVE_MODE;
        wait_bit(1'b1, 1, 60, seen);
        check8({7'h0, seen}, 8'h00, "no background");
        power_mode    = SLEEP_MODE;
        conv_value[1] = 8'd90;
        wait_bit(1'b0, 1, 60, seen);
        check8({7'h0, seen}, 8'h01, "sleep background");
        sfr_write(8'hf3, 8'h00);
        conv_value[1] = 8'hf0;
        wait_bit(1'b1, 1, 60, seen);
        check8({7'h0, seen}, 8'h01, "background with delta off");
        wait_bit(1'b0, 1, 15, seen);
        check8({7'h0, seen}, 8'h00, "delta off irq");
        check_reg(8'hd7, 8'd90);
        power_mode = FULL_POWER_MODE;
        sfr_write(8'hf9, 8'h00);
        $display("test delta done");
    endtask

    task automatic t_pll();
        pll_set = 1'b1;
        @(negedge i_clk);
        pll_set = 1'b0;
        @(negedge i_clk);
        check8({7'h0, pll_fault}, 8'h01, "pll flag set");
        sfr_write(8'hd8, 8'h80);
        @(negedge i_clk);
        check8({7'h0, pll_fault}, 8'h00, "pll flag cleared");
        check_reg(8'hd8, 8'h00);
        $display("test pll done");
    endtask

    initial begin
        miscompares = 0;
        n_compared  = 0;
        cycles      = 0;
        i_sys_rst   = 1'b1;
        sfr_addr    = 8'h00;
        sfr_wr      = 1'b0;
        sfr_wdata   = 8'h00;
        power_mode  = FULL_POWER_MODE;
        pll_set     = 1'b0;
        conv_value  = '0;
        slow        = 1'b0;
        repeat (10) @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_reset_regs();
        t_single();
        t_sleep_single();
        t_interval();
        t_delta();
        t_pll();
        report_and_stop();
    end
endmodule
